/* File: logic/spc_connect.sv */
// connect-status control of an addressable multidrop scan port transceiver
//
// What this block does
// - test sync address with chains paused enters multicast at once
// - multicast routes data in and mode select down, primary data out floats
// - no acknowledge is sent after a test sync address
// - test sync address valid only with both taps in a pause state
// - test sync address with either tap in reset or idle gives disconnect
// - bypass low connects primary to secondary regardless of earlier protocols
// - bypass low drives link active low
// - bypass fall connects both data paths without a test clock edge
// - bypass passes mode select, but test reset low holds it high
// - bypass holds the protocol receiver in its power-up state, ignoring selects
// - bypass release restores last valid status and re-enables reception
// - primary test reset always buffered to secondary test reset
// - test reset low without bypass: link inactive, both data outputs float
// - test reset low with bypass gives combined bypass and reset status
// - test reset low always forces secondary mode select high
// - shadow protocols ignored while test reset is low
// - without bypass, link active only after match or test sync result
// - otherwise, and during acknowledge, link active stays high
// - mode select change during select or acknowledge is a hard error
// - on status connects both data paths and mode select
// - off status floats both data outputs, holds mode select level
// - global disconnect code enters off with no acknowledge
// - reset code enters reset status, outputs float, mode select high
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module spc_connect (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_protocol_bypass_n,
  input  wire logic        i_primary_test_reset_n,
  input  wire logic        i_primary_test_clock,
  input  wire logic        i_primary_mode_select,
  input  wire logic        i_primary_data_in,
  input  wire logic        i_secondary_data_in,
  input  wire logic [9:0]  i_board_address_inputs,
  output logic             o_primary_data_out,
  output logic             o_primary_data_out_oe_n,
  output logic             o_secondary_data_out,
  output logic             o_secondary_data_out_oe_n,
  output logic             o_secondary_mode_select,
  output logic             o_secondary_test_reset_n,
  output logic             o_link_active_n,
  input  wire logic        i_sel_valid,
  input  wire logic [9:0]  i_sel_addr,
  input  wire logic        i_sel_busy,
  input  wire logic        i_ack_done,
  output logic             o_ack_start
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [15:0] pin_s;
  logic        byp_n_s;
  logic        trst_n_s;
  logic        tck_s;
  logic        primary_mode_select_s;
  logic        pdi_s;
  logic        sdi_s;
  logic [9:0]  board_s;

  spc_sync #(.W(16)) u_sync (
    .i_clk (i_clk),
    .i_d   ({i_board_address_inputs, i_secondary_data_in, i_primary_data_in,
             i_primary_mode_select, i_primary_test_clock, i_primary_test_reset_n,
             i_protocol_bypass_n}),
    .o_q   (pin_s)
  );

  // unpack the synchronised bundle
  assign byp_n_s  = pin_s[0];
  assign trst_n_s = pin_s[1];
  assign tck_s    = pin_s[2];
  assign primary_mode_select_s   = pin_s[3];
  assign pdi_s    = pin_s[4];
  assign sdi_s    = pin_s[5];
  assign board_s  = pin_s[15:6];

  ////////////////////////////////////////////////////////////////////////////
  // test clock edge and mode select change detection
  logic tck_d;
  logic primary_mode_select_d;
  logic tck_rise;
  logic ms_chg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tck_d  <= 1'b0;
      primary_mode_select_d <= 1'b1;
    end else begin
      tck_d  <= tck_s;
      primary_mode_select_d <= primary_mode_select_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d;
  assign ms_chg   = primary_mode_select_s ^ primary_mode_select_d;

  ////////////////////////////////////////////////////////////////////////////
  // tap followers; the secondary chain sees the mode select we drive
  spc_pkg::spc_tap_t ptap;
  spc_pkg::spc_tap_t stap;
  logic              both_pause;

  spc_tap_track u_ptap (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clr     (~trst_n_s),
    .i_step    (tck_rise),
    .i_tms     (primary_mode_select_s),
    .o_state   (ptap)
  );

  spc_tap_track u_stap (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clr     (~trst_n_s),
    .i_step    (tck_rise),
    .i_tms     (o_secondary_mode_select),
    .o_state   (stap)
  );

  // test sync needs both controllers parked in a pause state
  assign both_pause = (ptap == spc_pkg::TAP_PSDR || ptap == spc_pkg::TAP_PSIR) &&
                      (stap == spc_pkg::TAP_PSDR || stap == spc_pkg::TAP_PSIR);

  ////////////////////////////////////////////////////////////////////////////
  // protocol receipt gating and hard error detection
  logic ctrl_rx_en;
  logic rx_ok;
  logic ack_pend;
  logic sel_bad;
  logic herr_now;
  logic accept;
  logic hard_err;

  // bypass and test reset hold the receiver idle
  assign rx_ok    = byp_n_s & trst_n_s & ctrl_rx_en;
  assign herr_now = rx_ok & ms_chg & (i_sel_busy | ack_pend);
  // a select arriving during an acknowledge is not taken, so stray bits cannot reselect
  assign accept   = i_sel_valid & rx_ok & ~sel_bad & ~herr_now & ~ack_pend;

  // a select that saw a mode select change is discarded when it completes
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !rx_ok) begin
      sel_bad <= 1'b0;
    end else if (herr_now && i_sel_busy) begin
      sel_bad <= 1'b1;
    end else if (!i_sel_busy && !i_sel_valid) begin
      sel_bad <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode to the stored connect status
  spc_pkg::spc_stat_t conn;
  spc_pkg::spc_stat_t next_conn;
  logic               ack_req;

  always_comb begin
    next_conn = conn;
    ack_req   = 1'b0;
    if (accept) begin
      if (i_sel_addr == spc_pkg::RESET_CODE) begin
        next_conn = spc_pkg::SPC_RESET;
      end else if (i_sel_addr == spc_pkg::GLOBAL_DISCONNECT_CODE) begin
        next_conn = spc_pkg::SPC_OFF;
      end else if (i_sel_addr == spc_pkg::TEST_SYNC_ADDRESS) begin
        next_conn = both_pause ? spc_pkg::SPC_MCAST : spc_pkg::SPC_OFF;
      end else if (i_sel_addr == board_s) begin
        ack_req = 1'b1;
      end else begin
        next_conn = spc_pkg::SPC_OFF;
      end
    end else if (rx_ok && ack_pend && i_ack_done && !herr_now) begin
      next_conn = spc_pkg::SPC_ON; // on status only after the whole acknowledge
    end
  end

  // stored result survives bypass, so its release restores it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !trst_n_s) begin
      conn <= spc_pkg::SPC_OFF;
    end else begin
      conn <= next_conn;
    end
  end

  // acknowledge in flight; a hard error or bypass aborts it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !rx_ok) begin
      ack_pend <= 1'b0;
    end else if (ack_req) begin
      ack_pend <= 1'b1;
    end else if (i_ack_done || herr_now) begin
      ack_pend <= 1'b0;
    end
  end

  // start request to the serial acknowledge sender
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ack_start <= 1'b0;
    end else begin
      o_ack_start <= ack_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective status: test reset, then bypass, then stored result
  spc_pkg::spc_stat_t eff;

  always_comb begin
    if (!trst_n_s && !byp_n_s) begin
      eff = spc_pkg::SPC_BYPTRST;
    end else if (!trst_n_s) begin
      eff = spc_pkg::SPC_TRST;
    end else if (!byp_n_s) begin
      eff = spc_pkg::SPC_BYP;
    end else begin
      eff = conn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, registered; one system clock after sync, no test clock edge needed
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_primary_data_out        <= 1'b0;
      o_primary_data_out_oe_n   <= 1'b1;
      o_secondary_data_out      <= 1'b0;
      o_secondary_data_out_oe_n <= 1'b1;
      o_secondary_mode_select   <= 1'b1;
      o_link_active_n           <= 1'b1;
    end else begin
      case (eff)
        spc_pkg::SPC_ON, spc_pkg::SPC_BYP, spc_pkg::SPC_BYPTRST: begin
          o_primary_data_out        <= sdi_s;
          o_primary_data_out_oe_n   <= 1'b0;
          o_secondary_data_out      <= pdi_s;
          o_secondary_data_out_oe_n <= 1'b0;
          o_secondary_mode_select   <= (eff == spc_pkg::SPC_BYPTRST) ? 1'b1 : primary_mode_select_s;
          // bypass always shows active; on status stays inactive while acknowledging
          o_link_active_n           <= (eff == spc_pkg::SPC_ON) ? ack_pend : 1'b0;
        end
        spc_pkg::SPC_MCAST: begin
          o_primary_data_out        <= 1'b0;
          o_primary_data_out_oe_n   <= 1'b1;
          o_secondary_data_out      <= pdi_s;
          o_secondary_data_out_oe_n <= 1'b0;
          o_secondary_mode_select   <= primary_mode_select_s;
          o_link_active_n           <= ack_pend;
        end
        spc_pkg::SPC_RESET, spc_pkg::SPC_TRST: begin
          o_primary_data_out        <= 1'b0;
          o_primary_data_out_oe_n   <= 1'b1;
          o_secondary_data_out      <= 1'b0;
          o_secondary_data_out_oe_n <= 1'b1;
          o_secondary_mode_select   <= 1'b1;
          o_link_active_n           <= 1'b1;
        end
        default: begin
          o_primary_data_out        <= 1'b0;
          o_primary_data_out_oe_n   <= 1'b1;
          o_secondary_data_out      <= 1'b0;
          o_secondary_data_out_oe_n <= 1'b1;
          o_secondary_mode_select   <= o_secondary_mode_select; // chain stays in its tap state
          o_link_active_n           <= 1'b1;
        end
      endcase
    end
  end

  // test reset passes straight down the chain
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_secondary_test_reset_n <= 1'b1;
    end else begin
      o_secondary_test_reset_n <= trst_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped addresses answer with an error
  logic        apb_setup;
  logic        apb_acc;
  logic        hit_ctrl;
  logic        hit_stat;
  logic [31:0] stat_word;

  assign apb_setup = i_psel & ~i_penable;
  assign apb_acc   = i_psel & i_penable;
  assign hit_ctrl  = i_paddr == spc_pkg::CTRL_OFF;
  assign hit_stat  = i_paddr == spc_pkg::STAT_OFF;
  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc & ~(hit_ctrl | hit_stat);
  assign stat_word = {ptap, 5'h00, hard_err, ack_pend, ~trst_n_s, ~byp_n_s, eff};

  // read data is latched in the setup cycle so it stands as a flop output
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_setup && !i_pwrite) begin
      o_prdata <= hit_ctrl ? {31'h0000_0000, ctrl_rx_en} : (hit_stat ? stat_word : 32'h0000_0000);
    end
  end

  // receive enable: software can mute the receiver
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_rx_en <= spc_pkg::CTRL_RXEN_RV;
    end else if (apb_acc && i_pwrite && hit_ctrl) begin
      ctrl_rx_en <= i_pwdata[spc_pkg::CTRL_RXEN];
    end
  end

  // sticky hard error flag, write one to clear, a new error wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hard_err <= 1'b0;
    end else if (herr_now) begin
      hard_err <= 1'b1;
    end else if (apb_acc && i_pwrite && hit_stat && i_pwdata[spc_pkg::STAT_HERR]) begin
      hard_err <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_tsa_multicast: assert property (accept && i_sel_addr == spc_pkg::TEST_SYNC_ADDRESS && both_pause
    |=> conn == spc_pkg::SPC_MCAST && !o_ack_start) else $error("test sync did not enter multicast");
  a_tsa_bad_state: assert property (accept && i_sel_addr == spc_pkg::TEST_SYNC_ADDRESS && !both_pause
    |=> conn == spc_pkg::SPC_OFF) else $error("test sync outside pause did not disconnect");
  a_mcast_route: assert property (eff == spc_pkg::SPC_MCAST
    |=> o_secondary_data_out == $past(pdi_s) && o_primary_data_out_oe_n) else $error("multicast routing wrong");
  a_bypass_con_low: assert property (!byp_n_s |=> !o_link_active_n && !o_secondary_data_out_oe_n
    && !o_primary_data_out_oe_n) else $error("bypass did not connect");
  a_bypass_holds: assert property (!byp_n_s && trst_n_s |=> $stable(conn) && !ack_pend)
    else $error("receiver active during bypass");
  a_trst_float: assert property (!trst_n_s && byp_n_s |=> o_link_active_n && o_primary_data_out_oe_n
    && o_secondary_data_out_oe_n) else $error("test reset outputs not floating");
  a_trst_tms_high: assert property (!trst_n_s [*2] |-> o_secondary_mode_select)
    else $error("mode select not high under test reset");
  a_trst_buffer: assert property (##1 o_secondary_test_reset_n == $past(trst_n_s))
    else $error("test reset not buffered");
  a_ack_con_high: assert property (ack_pend && byp_n_s && trst_n_s |=> o_link_active_n)
    else $error("link active during acknowledge");
  a_dsa_off: assert property (accept && i_sel_addr == spc_pkg::GLOBAL_DISCONNECT_CODE
    |=> conn == spc_pkg::SPC_OFF ##1 !o_secondary_data_out_oe_n == 1'b0) else $error("disconnect code ignored");

  c_multicast: cover property (conn == spc_pkg::SPC_MCAST ##1 !o_link_active_n);
  c_match_on: cover property (ack_pend ##[1:200] conn == spc_pkg::SPC_ON);
  c_bypass_restore: cover property (!byp_n_s ##1 byp_n_s && conn == spc_pkg::SPC_ON);
  c_byp_trst: cover property (eff == spc_pkg::SPC_BYPTRST);
endmodule

/* File: logic/spc_pkg.sv */
// shared constants and types for the scan port connect control block
package spc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // apb register map
  localparam logic [11:0] CTRL_OFF     = 12'h000;
  localparam logic [11:0] STAT_OFF     = 12'h004;
  localparam int          CTRL_RXEN    = 0;
  localparam logic        CTRL_RXEN_RV = 1'b1;
  localparam int          STAT_HERR    = 10;

  ////////////////////////////////////////////////////////////////////////////
  // dedicated global addresses
  localparam logic [9:0] RESET_CODE             = 10'h000;
  localparam logic [9:0] GLOBAL_DISCONNECT_CODE = 10'h3fe;
  localparam logic [9:0] TEST_SYNC_ADDRESS      = 10'h3ff;

  ////////////////////////////////////////////////////////////////////////////
  // connect status, stored and effective
  typedef enum logic [6:0] {
    SPC_OFF     = 7'h01,
    SPC_ON      = 7'h02,
    SPC_MCAST   = 7'h04,
    SPC_RESET   = 7'h08,
    SPC_BYP     = 7'h10,
    SPC_TRST    = 7'h20,
    SPC_BYPTRST = 7'h40
  } spc_stat_t;

  // tap controller states
  typedef enum logic [15:0] {
    TAP_TLR   = 16'h0001,
    TAP_RTI   = 16'h0002,
    TAP_SELDR = 16'h0004,
    TAP_CAPDR = 16'h0008,
    TAP_SHDR  = 16'h0010,
    TAP_EX1DR = 16'h0020,
    TAP_PSDR  = 16'h0040,
    TAP_EX2DR = 16'h0080,
    TAP_UPDR  = 16'h0100,
    TAP_SELIR = 16'h0200,
    TAP_CAPIR = 16'h0400,
    TAP_SHIR  = 16'h0800,
    TAP_EX1IR = 16'h1000,
    TAP_PSIR  = 16'h2000,
    TAP_EX2IR = 16'h4000,
    TAP_UPIR  = 16'h8000
  } spc_tap_t;

endpackage

/* File: logic/spc_sync.sv */
// two flip-flop synchroniser for a bundle of pins
`timescale 1ns/10ps
module spc_sync #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;

  // the first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    meta <= i_d;
    o_q  <= meta;
  end
endmodule

/* File: logic/spc_tap_track.sv */
// follower of a tap controller state, stepped on test clock rising edges
`timescale 1ns/10ps
module spc_tap_track (
  input  wire logic      i_clk,
  input  wire logic      i_sys_rst,
  input  wire logic      i_clr,
  input  wire logic      i_step,
  input  wire logic      i_tms,
  output spc_pkg::spc_tap_t o_state
);
  spc_pkg::spc_tap_t next_state;

  // standard sixteen-state tap walk
  always_comb begin
    case (o_state)
      spc_pkg::TAP_TLR:   next_state = i_tms ? spc_pkg::TAP_TLR   : spc_pkg::TAP_RTI;
      spc_pkg::TAP_RTI:   next_state = i_tms ? spc_pkg::TAP_SELDR : spc_pkg::TAP_RTI;
      spc_pkg::TAP_SELDR: next_state = i_tms ? spc_pkg::TAP_SELIR : spc_pkg::TAP_CAPDR;
      spc_pkg::TAP_CAPDR: next_state = i_tms ? spc_pkg::TAP_EX1DR : spc_pkg::TAP_SHDR;
      spc_pkg::TAP_SHDR:  next_state = i_tms ? spc_pkg::TAP_EX1DR : spc_pkg::TAP_SHDR;
      spc_pkg::TAP_EX1DR: next_state = i_tms ? spc_pkg::TAP_UPDR  : spc_pkg::TAP_PSDR;
      spc_pkg::TAP_PSDR:  next_state = i_tms ? spc_pkg::TAP_EX2DR : spc_pkg::TAP_PSDR;
      spc_pkg::TAP_EX2DR: next_state = i_tms ? spc_pkg::TAP_UPDR  : spc_pkg::TAP_SHDR;
      spc_pkg::TAP_UPDR:  next_state = i_tms ? spc_pkg::TAP_SELDR : spc_pkg::TAP_RTI;
      spc_pkg::TAP_SELIR: next_state = i_tms ? spc_pkg::TAP_TLR   : spc_pkg::TAP_CAPIR;
      spc_pkg::TAP_CAPIR: next_state = i_tms ? spc_pkg::TAP_EX1IR : spc_pkg::TAP_SHIR;
      spc_pkg::TAP_SHIR:  next_state = i_tms ? spc_pkg::TAP_EX1IR : spc_pkg::TAP_SHIR;
      spc_pkg::TAP_EX1IR: next_state = i_tms ? spc_pkg::TAP_UPIR  : spc_pkg::TAP_PSIR;
      spc_pkg::TAP_PSIR:  next_state = i_tms ? spc_pkg::TAP_EX2IR : spc_pkg::TAP_PSIR;
      spc_pkg::TAP_EX2IR: next_state = i_tms ? spc_pkg::TAP_UPIR  : spc_pkg::TAP_SHIR;
      spc_pkg::TAP_UPIR:  next_state = i_tms ? spc_pkg::TAP_SELDR : spc_pkg::TAP_RTI;
      default:            next_state = spc_pkg::TAP_TLR;
    endcase
  end

  // a test reset forces test-logic-reset at once
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_clr) begin
      o_state <= spc_pkg::TAP_TLR;
    end else if (i_step) begin
      o_state <= next_state;
    end
  end
endmodule

/* File: bench/spc_scan_partner.sv */
// scan bus master test clock and mode select, plus secondary chain model
`timescale 1ns/10ps
module spc_scan_partner (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe_n,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_sdi
);
  // test clock stands low between steps
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_sdi = 1'b0;
  end
  // one 125 ns test clock period; mode select only moves while the clock is low
  task automatic tap_step(input logic tms);
    @(posedge i_clk);
    o_tms <= tms;
    #62.5 o_tck = 1'b1;
    #62.5 o_tck = 1'b0;
  endtask
  // mode select change outside any test clock period
  task automatic set_tms(input logic tms);
    @(posedge i_clk);
    o_tms <= tms;
  endtask
  // chain echoes driven data; a floating line toggles so it is never read as data
  always @(posedge i_clk) begin
    if (i_sdo_oe_n === 1'b0) begin
      o_sdi <= i_sdo;
    end else begin
      o_sdi <= ~o_sdi;
    end
  end
endmodule

/* File: bench/tb_scan_port_connect_control.sv */
// self-checking bench for the scan port connect control block
`timescale 1ns/10ps
module tb_scan_port_connect_control;
  localparam logic [9:0] BOARD = 10'h155;
  localparam logic [5:0] TAP_WALK = 6'h12; // mode select per step, first step in bit 0
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, byp_n = 1, trst_n = 1, pdi = 0;
  logic sel_valid = 0, sel_busy = 0, ack_done = 0, pready, pslverr, err, tck, tms, sdi;
  logic pdo, pdo_oe_n, sdo, sdo_oe_n, sms, secondary_test_reset_n_n, link_n, ack_start;
  logic [11:0] paddr = 0;
  logic [9:0]  sel_addr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  int          miscompares = 0, checked = 0;
  always #5 clk = ~clk;
  spc_connect spc_connect_i (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_protocol_bypass_n(byp_n), .i_primary_test_reset_n(trst_n), .i_primary_test_clock(tck),
    .i_primary_mode_select(tms), .i_primary_data_in(pdi), .i_secondary_data_in(sdi),
    .i_board_address_inputs(BOARD), .o_primary_data_out(pdo), .o_primary_data_out_oe_n(pdo_oe_n),
    .o_secondary_data_out(sdo), .o_secondary_data_out_oe_n(sdo_oe_n), .o_secondary_mode_select(sms),
    .o_secondary_test_reset_n(secondary_test_reset_n_n), .o_link_active_n(link_n), .i_sel_valid(sel_valid),
    .i_sel_addr(sel_addr), .i_sel_busy(sel_busy), .i_ack_done(ack_done), .o_ack_start(ack_start));
  spc_scan_partner spc_scan_partner_i (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n), .o_tck(tck),
    .o_tms(tms), .o_sdi(sdi));
  ////////////////////////////////////////////////////////////////////////////
  // comparison, bus and pin helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // apb transfer: request held until pready is sampled high; only the watchdog ends a stuck wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, spc_pkg::STAT_OFF, 32'h0);
    check(rd & mask, exp);
  endtask
  // pin order: link, primary out enable, secondary out enable, mode select, test reset
  task automatic pins(input logic [4:0] exp);
    check({27'h0, link_n, pdo_oe_n, sdo_oe_n, sms, secondary_test_reset_n_n}, {27'h0, exp});
  endtask
  // completed select; a busy select ends in the same cycle
  task automatic sel(input logic [9:0] a);
    @(posedge clk);
    sel_valid <= 1'b1;
    sel_busy <= 1'b0;
    sel_addr <= a;
    @(posedge clk);
    sel_valid <= 1'b0;
    // the one-cycle start pulse is looked at half a cycle after it is launched
    @(negedge clk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests take well under 30 us
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    cyc(4);
    rst <= 1'b0;
    cyc(3);
    apb(1'b0, spc_pkg::CTRL_OFF, 32'h0);
    check(rd, 32'h1);
    // a muted receiver takes no select at all
    apb(1'b1, spc_pkg::CTRL_OFF, 32'h0);
    sel(BOARD);
    check({31'h0, ack_start}, 32'h0);
    apb(1'b1, spc_pkg::CTRL_OFF, 32'h1);
    stat(32'hffffffff, 32'h0001_0001);
    apb(1'b0, 12'h008, 32'h0);
    check({31'h0, err}, 32'h1);
    pins(5'b11111);
    sel(spc_pkg::TEST_SYNC_ADDRESS);
    check({31'h0, ack_start}, 32'h0);
    cyc(3);
    stat(32'h7f, 32'h01);
    $display("reset values and early sync address done");
    sel(BOARD);
    check({31'h0, ack_start}, 32'h1);
    cyc(5);
    check({31'h0, link_n}, 32'h1);
    // master data held quiet during the acknowledge
    @(posedge clk);
    ack_done <= 1'b1;
    @(posedge clk);
    ack_done <= 1'b0;
    pdi <= 1'b1;
    cyc(8);
    pins(5'b00011);
    check({30'h0, sdo, pdo}, 32'h3);
    stat(32'h7f, 32'h02);
    $display("match and connect done");
    // walk both taps to pause-dr: idle, select, capture, shift, exit1, pause
    for (int i = 0; i < 6; i++) begin
      spc_scan_partner_i.tap_step(TAP_WALK[i]);
    end
    cyc(6);
    sel(spc_pkg::TEST_SYNC_ADDRESS);
    check({31'h0, ack_start}, 32'h0);
    cyc(3);
    pins(5'b01001);
    check({31'h0, sdo}, 32'h1);
    stat(32'hffff007f, 32'h0040_0004);
    $display("multicast done");
    @(posedge clk);
    sel_busy <= 1'b1;
    spc_scan_partner_i.set_tms(1'b1);
    cyc(4);
    spc_scan_partner_i.set_tms(1'b0);
    cyc(4);
    sel(spc_pkg::GLOBAL_DISCONNECT_CODE);
    cyc(3);
    stat(32'h47f, 32'h404);
    apb(1'b1, spc_pkg::STAT_OFF, 32'h400);
    stat(32'h400, 32'h0);
    $display("hard error done");
    sel(spc_pkg::GLOBAL_DISCONNECT_CODE);
    cyc(3);
    pins(5'b11101);
    stat(32'h7f, 32'h01);
    sel(spc_pkg::RESET_CODE);
    cyc(3);
    pins(5'b11111);
    stat(32'h7f, 32'h08);
    $display("disconnect and reset codes done");
    byp_n <= 1'b0;
    cyc(8);
    pins(5'b00001);
    check({30'h0, sdo, pdo}, 32'h3);
    stat(32'hff, 32'h90);
    sel(BOARD);
    check({31'h0, ack_start}, 32'h0);
    @(posedge clk);
    byp_n <= 1'b1;
    cyc(4);
    stat(32'h7f, 32'h08);
    // an address that is neither ours nor a global one deselects
    sel(BOARD ^ 10'h001);
    cyc(3);
    stat(32'h7f, 32'h01);
    $display("bypass done");
    trst_n <= 1'b0;
    cyc(4);
    pins(5'b11110);
    stat(32'h1ff, 32'h120);
    sel(BOARD);
    check({31'h0, ack_start}, 32'h0);
    @(posedge clk);
    byp_n <= 1'b0;
    cyc(4);
    pins(5'b00010);
    stat(32'h1ff, 32'h1c0);
    byp_n <= 1'b1;
    trst_n <= 1'b1;
    cyc(4);
    check({31'h0, sms}, 32'h1);
    $display("test reset done");
    complete_run();
  end
endmodule
